// [osc_params.svh]
// constants for the oscillator select control block
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH
`define OSC_PERIPH_ID       8'h04
`define OSC_GEN_CTRL_OFS    8'h00
`define OSC_INT_CTRL_OFS    8'h01
`define OSC_XTAL_CTRL_OFS   8'h02
`define OSC_SEL_BIT         0
`define OSC_TILE_RST_BIT    1
`define OSC_INT_EN_BIT      0
`define OSC_INT_SLOW_BIT    1
`define OSC_XTAL_EN_BIT     0
`define OSC_XTAL_BIAS_BIT   1
`define OSC_TILE_RST_RESET  1'b0
`define OSC_INT_EN_RESET    1'b1
`define OSC_INT_SLOW_RESET  1'b0
`define OSC_XTAL_EN_RESET   1'b1
`define OSC_XTAL_BIAS_RESET 1'b1
`define OSC_TILE_RST_NS     100
`define OSC_CLK_NS          100
`define OSC_TILE_RST_CYC    ((`OSC_TILE_RST_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
`endif

// [osc_pkg.sv]
// types shared by the oscillator select control block
package osc_pkg;
  typedef logic [7:0] osc_byte_t;
  typedef logic [1:0] osc_reg_sel_t;
  typedef enum logic [1:0] {OSC_NONE, OSC_GEN, OSC_INT, OSC_XTAL} osc_reg_e;
endpackage

// [osc_bus_if.sv]
// register access bundle between the decoder and the register file
`timescale 1ns/1ps
interface osc_bus_if;
  import osc_pkg::*;
  logic     wr;
  logic     rd;
  osc_reg_e sel;
  osc_byte_t wdata;
  modport dec (output wr, output rd, output sel, output wdata);
  modport regs (input wr, input rd, input sel, input wdata);
endinterface

// [osc_decode.sv]
// decodes peripheral number and byte offset into a register select
`timescale 1ns/1ps
`include "osc_params.svh"
module osc_decode
  import osc_pkg::*;
(
  input  wire logic [7:0] periph,
  input  wire logic [7:0] addr,
  input  wire logic       wr_req,
  input  wire logic       rd_req,
  input  wire logic [7:0] wdata,
  osc_bus_if.dec          bus
);
  function automatic osc_reg_e dec_reg(input logic [7:0] p, input logic [7:0] a);
    if (p != `OSC_PERIPH_ID) return OSC_NONE; // R1
    unique case (a)
      `OSC_GEN_CTRL_OFS:  return OSC_GEN;
      `OSC_INT_CTRL_OFS:  return OSC_INT;
      `OSC_XTAL_CTRL_OFS: return OSC_XTAL;
      default:            return OSC_NONE;
    endcase
  endfunction

  always_comb begin
    bus.sel   = dec_reg(periph, addr);
    bus.wr    = wr_req;
    bus.rd    = rd_req;
    bus.wdata = wdata; // R2
  end
endmodule // osc_decode

// [osc_select_ctrl.sv]
// oscillator select control registers reached as byte-wide peripheral 4
`timescale 1ns/1ps
`include "osc_params.svh"
// Operation
// R1: answers as peripheral number four only; rd_valid follows every read taken with clk_en high, other numbers read zero
// R2: every access is one byte wide
// R3: bit0 selects crystal or internal; strap reset
// R4: select change resets tile when enabled
// R5: internal oscillator speed bit, fast by default
// R6: internal oscillator enable, reset to one
// R7: software stops only the unused oscillator
// R8: crystal bias enable, reset to one
// R9: crystal oscillator enable, reset to one
// R10: reserved bits read zero, ignore writes
module osc_select_ctrl
  import osc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       sel_strap,
  input  wire logic [7:0] periph,
  input  wire logic [7:0] addr,
  input  wire logic       wr_req,
  input  wire logic       rd_req,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            rd_valid,
  output logic            osc_sel,
  output logic            int_osc_en,
  output logic            int_osc_slow,
  output logic            xtal_en,
  output logic            xtal_bias_en,
  output logic            tile_reset
);
  osc_bus_if bus ();

  osc_decode osc_decode_i (
    .periph (periph),
    .addr   (addr),
    .wr_req (wr_req),
    .rd_req (rd_req),
    .wdata  (wdata),
    .bus    (bus)
  );

  logic       strap_pend_r;
  logic       tile_rst_en_r;
  logic [1:0] rst_cnt_r;
  logic       sel_nxt;

  // strap is sampled on the first enabled edge after reset release, never under reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_pend_r <= 1'b1;
    end else if (clk_en) begin
      strap_pend_r <= 1'b0;
    end
  end

  always_comb begin
    sel_nxt = osc_sel;
    if (strap_pend_r) begin
      sel_nxt = sel_strap; // R3
    end else if (bus.wr && bus.sel == OSC_GEN) begin
      sel_nxt = bus.wdata[`OSC_SEL_BIT]; // R3
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_sel <= 1'b0;
    end else if (clk_en) begin
      osc_sel <= sel_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tile_rst_en_r <= `OSC_TILE_RST_RESET;
    end else if (clk_en && bus.wr && bus.sel == OSC_GEN) begin
      tile_rst_en_r <= bus.wdata[`OSC_TILE_RST_BIT]; // R4
    end
  end

  // pulse uses the enable as it stood before this write, so enabling and
  // switching in one write does not reset the tile
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rst_cnt_r  <= 2'h0;
      tile_reset <= 1'b0;
    end else if (clk_en) begin
      if (!strap_pend_r && tile_rst_en_r && sel_nxt != osc_sel) begin
        rst_cnt_r  <= 2'(`OSC_TILE_RST_CYC); // R4
        tile_reset <= 1'b1;
      end else if (rst_cnt_r > 2'h1) begin
        rst_cnt_r  <= rst_cnt_r - 2'h1;
      end else begin
        rst_cnt_r  <= 2'h0;
        tile_reset <= 1'b0;
      end
    end
  end

  // no interlock against stopping the clock in use: left to software
  always_ff @(posedge core_clk) begin
    if (reset) begin
      int_osc_en   <= `OSC_INT_EN_RESET;
      int_osc_slow <= `OSC_INT_SLOW_RESET;
    end else if (clk_en && bus.wr && bus.sel == OSC_INT) begin
      int_osc_en   <= bus.wdata[`OSC_INT_EN_BIT]; // R6 R7
      int_osc_slow <= bus.wdata[`OSC_INT_SLOW_BIT]; // R5
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      xtal_en      <= `OSC_XTAL_EN_RESET;
      xtal_bias_en <= `OSC_XTAL_BIAS_RESET;
    end else if (clk_en && bus.wr && bus.sel == OSC_XTAL) begin
      xtal_en      <= bus.wdata[`OSC_XTAL_EN_BIT]; // R9
      xtal_bias_en <= bus.wdata[`OSC_XTAL_BIAS_BIT]; // R8
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata    <= 8'h00;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= bus.rd;
      if (bus.rd) begin
        unique case (bus.sel)
          OSC_GEN:  rdata <= {6'h00, tile_rst_en_r, osc_sel}; // R10
          OSC_INT:  rdata <= {6'h00, int_osc_slow, int_osc_en}; // R10
          OSC_XTAL: rdata <= {6'h00, xtal_bias_en, xtal_en}; // R10
          OSC_NONE: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // osc_select_ctrl

// [osc_select_ctrl_sva.sv]
// port assertions for the oscillator select block
`timescale 1ns/1ps
module osc_select_ctrl_sva(
  input wire logic       core_clk, reset, clk_en, wr_req, rd_req, rd_valid, tile_reset,
  input wire logic [7:0] periph, addr, wdata, rdata,
  input wire logic       osc_sel, int_osc_en, int_osc_slow, xtal_en, xtal_bias_en);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire w = clk_en && wr_req && periph == 8'h04;
  a_read_answered: assert property (clk_en && rd_req |=> rd_valid) else $error("no reply");
  a_reserved_zero: assert property (rd_valid |-> rdata[7:2] == 0) else $error("reserved");
  a_miss_reads_zero: assert property (clk_en && rd_req && periph != 8'h04 |=> rdata == 0) else $error("miss");
  a_sel_write: assert property (w && addr == 0 |=> osc_sel == $past(wdata[0])) else $error("sel");
  a_int_write: assert property (w && addr == 1 |=> {int_osc_slow, int_osc_en} == $past(wdata[1:0])) else $error("int");
  a_xtal_write: assert property (w && addr == 2 |=> {xtal_bias_en, xtal_en} == $past(wdata[1:0])) else $error("xtal");
  a_tile_rst_cause: assert property ($rose(tile_reset) |-> osc_sel != $past(osc_sel)) else $error("cause");
  a_tile_rst_pulse: assert property (tile_reset && clk_en |=> !tile_reset || osc_sel != $past(osc_sel)) else $error("pulse");
  c_tile_rst: cover property (tile_reset);
  c_read: cover property (rd_valid);
  c_xtal_off: cover property (!xtal_en);
endmodule // osc_select_ctrl_sva
bind osc_select_ctrl osc_select_ctrl_sva osc_select_ctrl_sva_i(.*);

// [osc_tile_model.sv]
// processor tile model issuing byte-wide peripheral accesses
`timescale 1ns/1ps
module osc_tile_model(
  input wire logic       core_clk, rd_valid,
  input wire logic [7:0] rdata,
  output logic     [7:0] periph, addr, wdata,
  output logic           wr_req, rd_req);
  initial {periph, addr, wdata, wr_req, rd_req} = '0;
  task automatic acc(logic w, logic [7:0] p, a, d, output logic [7:0] q, output logic v);
    @(posedge core_clk);
    {periph, addr, wdata, wr_req, rd_req} <= {p, a, d, w, !w};
    @(posedge core_clk);
    // released address and data lines invert and both strobes drop, so a stale value never looks live
    {periph, addr, wdata, wr_req, rd_req} <= {~p, ~a, ~d, 2'b00};
    #1 q = rdata;
    v = rd_valid;
  endtask
endmodule // osc_tile_model

// [osc_select_ctrl_tb.sv]
// self-checking bench for the oscillator select block
`timescale 1ns/1ps
module osc_select_ctrl_tb;
  logic       core_clk = 0, reset = 1, sel_strap = 1, clk_en = 1, wr_req, rd_req, rd_valid, v;
  logic       tile_reset;
  logic       osc_sel, int_osc_en, int_osc_slow, xtal_en, xtal_bias_en;
  logic [7:0] periph, addr, wdata, rdata, q;
  int         n_fail = 0, checked = 0;
  always #50 core_clk = ~core_clk;
  osc_select_ctrl osc_select_ctrl_i(.*);
  osc_tile_model osc_tile_model_i(.*);
  task automatic cmp(string s, logic [8:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, d, logic [8:0] e);
    osc_tile_model_i.acc(1, 8'h04, a, d, q, v);
    cmp("outs", e, {3'h0, tile_reset, osc_sel, int_osc_slow, int_osc_en, xtal_bias_en, xtal_en});
  endtask
  task automatic rd(logic [7:0] p, a, e);
    osc_tile_model_i.acc(0, p, a, 8'h00, q, v);
    cmp("read", {1'b1, e}, {v, q});
  endtask
  task automatic t_reset;
    rd(8'h04, 8'h00, 8'h01);
    rd(8'h04, 8'h01, 8'h01);
    rd(8'h04, 8'h02, 8'h03);
    $display("t_reset done");
  endtask
  task automatic t_switch;
    wr(8'h00, 8'hfe, 9'h07);
    wr(8'h00, 8'hff, 9'h37);
    rd(8'h04, 8'h00, 8'h03);
    wr(8'h00, 8'h02, 9'h27);
    wr(8'h01, 8'hfe, 9'h0b);
    rd(8'h04, 8'h01, 8'h02);
    $display("t_switch done");
  endtask
  task automatic t_xtal;
    wr(8'h01, 8'h01, 9'h07);
    wr(8'h00, 8'h03, 9'h37);
    wr(8'h02, 8'hfc, 9'h14);
    osc_tile_model_i.acc(1, 8'h05, 8'h02, 8'h03, q, v);
    wr(8'h03, 8'h03, 9'h14);
    rd(8'h05, 8'h00, 8'h00);
    rd(8'h04, 8'h02, 8'h00);
    $display("t_xtal done");
  endtask
  // a write with the enable low must change nothing; then a mid-run reset with the strap low
  task automatic t_freeze;
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(8'h02, 8'h03, 9'h14);
    @(posedge core_clk);
    clk_en <= 1'b1;
    sel_strap <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h04, 8'h00, 8'h00);
    rd(8'h04, 8'h02, 8'h03);
    $display("t_freeze done");
  endtask
  task automatic report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 0;
    t_reset;
    t_switch;
    t_xtal;
    t_freeze;
    report_and_stop;
  end
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
endmodule // osc_select_ctrl_tb
